// ---- core/wsc_defs.svh ----
// Constants for the watchdog, sleep and wake controller.
// Included by the top core file by bare name; definitions only.
`ifndef WSC_DEFS_SVH
`define WSC_DEFS_SVH

// Register byte offsets
`define WSC_OFF_CTRL   8'h00
`define WSC_OFF_CMD    8'h04
`define WSC_OFF_OSC    8'h08
`define WSC_OFF_STAT   8'h0C

// Control register fields
`define WSC_B_EXPIRED  4
`define WSC_B_SOFT_EN  5
`define WSC_B_LEVEL_LO 8
`define WSC_B_SD_EN    12
`define WSC_B_REF      13

// Command register fields
`define WSC_B_KICK     0
`define WSC_B_PSAVE    1
`define WSC_B_PS_SLEEP 2

// Oscillator control fields
`define WSC_B_LP_KEEP  8

// Reset values
`define WSC_FUSE_ERASED 1'b1
`define WSC_RST_EXPIRED 1'b1
`define WSC_RST_LEVEL   4'h0

// Clock source codes (current-oscillator and group fields)
`define WSC_SRC_FRC     3'h0
`define WSC_SRC_SLOW_INTERNAL_RC    3'h1
`define WSC_SRC_LP      3'h2
`define WSC_SRC_PRIMARY 3'h3
`define WSC_SRC_FRC_PLL 3'h4

// Primary oscillator kinds, bits 4:3 of the primary field
`define WSC_PK_EXTCLK  2'h0
`define WSC_PK_STD     2'h1
`define WSC_PK_HS      2'h2
`define WSC_PK_ERC     2'h3

// AXI responses
`define WSC_RESP_OKAY   2'h0
`define WSC_RESP_SLVERR 2'h2

// Timing
`define WSC_CLK_NS     100
`define WSC_POWERON_DELAY_NS    10000
`define WSC_PLL_SETTLE_DELAY_NS   20000
`define WSC_POWERUP_TIMER_DELAY_NS   16000000
`define WSC_OST_CYC    1024
`define WSC_WDT_W      16
`define WSC_WAKE_W     24

`endif

// ---- core/wsc_pkg.sv ----
// Types shared by the watchdog, sleep and wake controller.
// No dependencies.
package wsc_pkg;

  // Power states of the controller
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_RUN,
    ST_IDLE,
    ST_SLEEP,
    ST_LOAD,
    ST_WAKE,
    ST_LOCK
  } wsc_state_t;

endpackage

// ---- core/wsc_wdt.sv ----
// Watchdog counter stepped by the slow internal RC oscillator.
// The RC pin is asynchronous to aclk and is synchronised here.
`timescale 1ns/1ns
module wsc_wdt #(
  parameter int WDT_W = 16
) (
  input  wire logic             aclk,      // System clock
  input  wire logic             aresetn,   // Sync reset, low
  input  wire logic             rc_pin,    // Slow RC oscillator
  input  wire logic             enable,    // Watchdog on
  input  wire logic             restart,   // Clear count
  output logic                  overflow,  // One-cycle time-out
  output logic [WDT_W-1:0]      count      // Present count
);

  logic rc_s1_reg;
  logic rc_s2_reg;
  logic rc_s3_reg;
  logic rc_tick;
  logic at_top;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop sync, third flop only for the edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else begin
      rc_s1_reg <= rc_pin;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  // Steps on the RC edge, never on the main oscillator
  assign rc_tick = rc_s2_reg & ~rc_s3_reg;
  assign at_top  = &count;

  ////////////////////////////////////////////////////////////////////////
  // Counts until it wraps; the wrap is the time-out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count    <= '0;
      overflow <= 1'b0;
    end else if (!enable || restart) begin
      count    <= '0;
      overflow <= 1'b0;
    end else begin
      count    <= rc_tick ? count + 1'b1 : count;
      overflow <= rc_tick & at_top;
    end
  end

endmodule

// ---- core/wsc_top.sv ----
// Watchdog, supply-drop control, Sleep/Idle entry and wake sequencing,
// reached over AXI4-Lite.
// Assumes one clock; pins and the RC oscillator are asynchronous.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "wsc_defs.svh"
module wsc_top #(
  parameter int POWERUP_TIMER_CYC = `WSC_POWERUP_TIMER_DELAY_NS / `WSC_CLK_NS,
  parameter int OST_CYC  = `WSC_OST_CYC,
  parameter int WDT_W    = `WSC_WDT_W
) (
  input  wire logic        aclk,             // 10 MHz clock
  input  wire logic        aresetn,          // Sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,     // Write address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output logic             s_axi_awready,    // Write address ready
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Byte strobes
  input  wire logic        s_axi_wvalid,     // Write data valid
  output logic             s_axi_wready,     // Write data ready
  output logic [1:0]       s_axi_bresp,      // Write response
  output logic             s_axi_bvalid,     // Response valid
  input  wire logic        s_axi_bready,     // Response ready
  input  wire logic [7:0]  s_axi_araddr,     // Read address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output logic             s_axi_arready,    // Read address ready
  output logic [31:0]      s_axi_rdata,      // Read data
  output logic [1:0]       s_axi_rresp,      // Read response
  output logic             s_axi_rvalid,     // Read valid
  input  wire logic        s_axi_rready,     // Read ready
  input  wire logic        watchdog_fuse_enable, // Fuse, static
  input  wire logic [2:0]  osc_group_cfg,    // Fuse, static
  input  wire logic [4:0]  primary_osc_cfg,  // Fuse, static
  input  wire logic        clk_switch_cfg,   // Fuse, static
  input  wire logic        slow_internal_rc, // RC oscillator pin
  input  wire logic        reference_pin,    // Reference stable, async
  input  wire logic        pll_locked,       // PLL lock, async
  input  wire logic        brownout_reset,   // POR or BOR event, async
  input  wire logic        master_clear_pin, // Master clear, async
  input  wire logic        irq_wake,         // Qualified interrupt
  output logic             cpu_clk_en,       // CPU clock gate
  output logic             periph_clk_en,    // Peripheral clock gate
  output logic             osc_run,          // Oscillator enable
  output logic             pll_en,           // PLL enable
  output logic [1:0]       pll_mult,         // 1:x4 2:x8 3:x16
  output logic [1:0]       pll_prediv,       // 0:none 1:/2 2:/3
  output logic             fail_safe_mon_en, // Clock monitor on
  output logic             slow_rc_run,      // RC oscillator enable
  output logic             wdt_reset,        // Device reset pulse
  output logic             supply_drop_enable, // Detector enable
  output logic [3:0]       supply_drop_level,  // Detector threshold
  output logic             osc2_wave,        // Second pin level
  output logic             osc2_oe,          // Second pin drive
  output logic             osc2_is_io        // Second pin is I/O
);

  localparam int POWERON_DELAY_CYC =
    (`WSC_POWERON_DELAY_NS + `WSC_CLK_NS - 1) / `WSC_CLK_NS;
  localparam int PLL_SETTLE_DELAY_CYC =
    (`WSC_PLL_SETTLE_DELAY_NS + `WSC_CLK_NS - 1) / `WSC_CLK_NS;
  localparam int WW = `WSC_WAKE_W;

  wsc_pkg::wsc_state_t state_reg;
  wsc_pkg::wsc_state_t state_next;

  logic [3:0]       pin_raw;
  logic [3:0]       pin_s1_reg;
  logic [3:0]       pin_s2_reg;
  logic [3:0]       pin_s3_reg;
  logic             ref_ok;
  logic             lock_ok;
  logic             rst_evt;
  logic             por_evt;
  logic             aw_have;
  logic             w_have;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic [31:0]      wmask;
  logic [31:0]      wval;
  logic             wr_fire;
  logic             wr_ctrl;
  logic             wr_cmd;
  logic             wr_osc;
  logic             wr_hit;
  logic             rd_take;
  logic [31:0]      rd_word;
  logic             rd_hit;
  logic             soft_en_reg;
  logic             expired_reg;
  logic             fuse_reg;
  logic [2:0]       group_reg;
  logic [4:0]       prim_reg;
  logic             switch_reg;
  logic [2:0]       cur_osc_reg;
  logic             lp_keep_reg;
  logic             from_sleep_reg;
  logic [WW-1:0]    wake_cnt_reg;
  logic [1:0]       div_reg;
  logic             kick;
  logic             psave;
  logic             ps_sleep;
  logic             wdt_on;
  logic             wdt_ovf;
  logic [WDT_W-1:0] wdt_count;
  logic [2:0]       src;
  logic [1:0]       pkind;
  logic             src_prim;
  logic             src_lp;
  logic             uses_xtal;
  logic             uses_pll;
  logic             lp_short;
  logic             slow_path;
  logic [WW-1:0]    delay_cyc;
  logic             sleeping;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are taken from the second stage onward
  assign pin_raw = {master_clear_pin, brownout_reset,
                    pll_locked, reference_pin};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_s3_reg <= 4'h0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign ref_ok  = pin_s2_reg[0];
  assign lock_ok = pin_s2_reg[1];
  assign por_evt = pin_s2_reg[2] & ~pin_s3_reg[2];
  assign rst_evt = por_evt | (pin_s2_reg[3] & ~pin_s3_reg[3]);

  ////////////////////////////////////////////////////////////////////////
  // AXI write side: address and data in either order, then response
  assign aw_have = ~s_axi_awready;
  assign w_have  = ~s_axi_wready;
  assign wr_fire = aw_have & w_have & ~s_axi_bvalid;
  assign wr_ctrl = wr_fire && (aw_addr_reg == `WSC_OFF_CTRL);
  assign wr_cmd  = wr_fire && (aw_addr_reg == `WSC_OFF_CMD);
  assign wr_osc  = wr_fire && (aw_addr_reg == `WSC_OFF_OSC);
  assign wr_hit  = wr_ctrl | wr_cmd | wr_osc |
                   (aw_addr_reg == `WSC_OFF_STAT);

  // Strobes widened to a bit mask, one lane per byte
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{w_strb_reg[gi]}};
    end
  endgenerate

  assign wval     = w_data_reg & wmask;
  assign kick     = wr_cmd & wval[`WSC_B_KICK];
  assign psave    = wr_cmd & wval[`WSC_B_PSAVE];
  assign ps_sleep = wval[`WSC_B_PS_SLEEP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WSC_RESP_OKAY;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `WSC_RESP_OKAY : `WSC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI read side: one read at a time, data one cycle after address
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rd_hit  = (s_axi_araddr == `WSC_OFF_CTRL) ||
                   (s_axi_araddr == `WSC_OFF_CMD) ||
                   (s_axi_araddr == `WSC_OFF_OSC) ||
                   (s_axi_araddr == `WSC_OFF_STAT);

  // Reference bit is read-only and follows the pin
  assign rd_word =
    (s_axi_araddr == `WSC_OFF_CTRL) ?
      {18'h0, ref_ok, supply_drop_enable, supply_drop_level,
       2'h0, soft_en_reg, expired_reg, 4'h0} :
    (s_axi_araddr == `WSC_OFF_OSC) ?
      {23'h0, lp_keep_reg, 5'h0, cur_osc_reg} :
    (s_axi_araddr == `WSC_OFF_STAT) ?
      {16'(wdt_count), 8'h0, 1'b0, switch_reg, fuse_reg,
       lock_ok, 1'b0, state_reg} :
      32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WSC_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? `WSC_RESP_OKAY : `WSC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and oscillator registers, plus fuse capture after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_en_reg        <= 1'b0;
      supply_drop_enable <= 1'b0;
      supply_drop_level  <= `WSC_RST_LEVEL;
      lp_keep_reg        <= 1'b0;
      fuse_reg           <= `WSC_FUSE_ERASED;
      group_reg          <= `WSC_SRC_FRC;
      prim_reg           <= 5'h00;
      switch_reg         <= 1'b0;
    end else begin
      if (state_reg == wsc_pkg::ST_BOOT) begin
        fuse_reg   <= watchdog_fuse_enable;
        group_reg  <= osc_group_cfg;
        prim_reg   <= primary_osc_cfg;
        switch_reg <= clk_switch_cfg;
      end
      if (wr_ctrl && w_strb_reg[0]) begin
        soft_en_reg <= w_data_reg[`WSC_B_SOFT_EN];
      end
      if (wr_ctrl && w_strb_reg[1]) begin
        supply_drop_level  <= w_data_reg[`WSC_B_LEVEL_LO +: 4];
        supply_drop_enable <= w_data_reg[`WSC_B_SD_EN];
      end
      if (wr_osc && w_strb_reg[1]) begin
        lp_keep_reg <= w_data_reg[`WSC_B_LP_KEEP];
      end
    end
  end

  // Hardware clear wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expired_reg <= `WSC_RST_EXPIRED;
    end else if (sleeping && wdt_ovf) begin
      expired_reg <= 1'b0;
    end else if (wr_ctrl && w_strb_reg[0]) begin
      expired_reg <= w_data_reg[`WSC_B_EXPIRED];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: fuse forces it on, else software chooses
  assign wdt_on = fuse_reg | soft_en_reg;

  wsc_wdt #(
    .WDT_W (WDT_W)
  ) wsc_wdt_i (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .rc_pin   (slow_internal_rc),
    .enable   (wdt_on),
    .restart  (kick),
    .overflow (wdt_ovf),
    .count    (wdt_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock source and the delay it needs on wake
  // Without switching there is one system clock, the fuse choice
  assign src      = switch_reg ? cur_osc_reg : group_reg;
  assign pkind    = prim_reg[4:3];
  assign src_prim = (src == `WSC_SRC_PRIMARY);
  assign src_lp   = (src == `WSC_SRC_LP);
  assign uses_xtal = src_lp || (src_prim &&
                     (pkind == `WSC_PK_STD || pkind == `WSC_PK_HS));
  // External RC has no PLL path; others take x4, x8 or x16
  assign uses_pll = (prim_reg[1:0] != 2'h0) &&
                    ((src_prim && pkind != `WSC_PK_ERC) ||
                     src == `WSC_SRC_FRC_PLL);
  assign lp_short  = src_lp && lp_keep_reg && from_sleep_reg;
  assign slow_path = (uses_xtal || uses_pll) && !lp_short;

  // Fast sources pay only the power-on delay
  assign delay_cyc = WW'(POWERON_DELAY_CYC +
                         (slow_path ? POWERUP_TIMER_CYC : 0) +
                         (slow_path && uses_xtal ? OST_CYC : 0) +
                         (slow_path && uses_pll ? PLL_SETTLE_DELAY_CYC : 0));

  assign sleeping = (state_reg == wsc_pkg::ST_SLEEP);

  ////////////////////////////////////////////////////////////////////////
  // Power state sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wsc_pkg::ST_BOOT: begin
        state_next = wsc_pkg::ST_LOAD;
      end
      wsc_pkg::ST_RUN: begin
        if (rst_evt) begin
          state_next = wsc_pkg::ST_LOAD;
        end else if (psave) begin
          state_next = ps_sleep ? wsc_pkg::ST_SLEEP : wsc_pkg::ST_IDLE;
        end
      end
      wsc_pkg::ST_IDLE: begin
        if (rst_evt) begin
          state_next = wsc_pkg::ST_LOAD;
        end else if (irq_wake || wdt_ovf) begin
          state_next = wsc_pkg::ST_RUN;
        end
      end
      wsc_pkg::ST_SLEEP: begin
        if (irq_wake || rst_evt || wdt_ovf) begin
          state_next = wsc_pkg::ST_LOAD;
        end
      end
      wsc_pkg::ST_LOAD: begin
        state_next = wsc_pkg::ST_WAKE;
      end
      wsc_pkg::ST_WAKE: begin
        if (wake_cnt_reg == '0) begin
          state_next = uses_pll ? wsc_pkg::ST_LOCK : wsc_pkg::ST_RUN;
        end
      end
      wsc_pkg::ST_LOCK: begin
        if (lock_ok) begin
          state_next = wsc_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = wsc_pkg::ST_BOOT;
      end
    endcase
  end

  // State, wake counter and the clock to restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= wsc_pkg::ST_BOOT;
      wake_cnt_reg   <= '0;
      cur_osc_reg    <= `WSC_SRC_FRC;
      from_sleep_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == wsc_pkg::ST_LOAD) begin
        wake_cnt_reg <= delay_cyc - 1'b1;
      end else if (wake_cnt_reg != '0) begin
        wake_cnt_reg <= wake_cnt_reg - 1'b1;
      end
      // Power-on style events reload the fuse choice
      if (state_reg == wsc_pkg::ST_BOOT || por_evt) begin
        cur_osc_reg <= osc_group_cfg;
      end else if (wr_osc && w_strb_reg[0] && switch_reg) begin
        cur_osc_reg <= w_data_reg[2:0];
      end
      if (state_next == wsc_pkg::ST_RUN) begin
        from_sleep_reg <= 1'b0;
      end else if (sleeping) begin
        from_sleep_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered clock gates and enables; gates, osc_run, pll_en and monitor from the next state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en       <= 1'b0;
      periph_clk_en    <= 1'b0;
      osc_run          <= 1'b0;
      pll_en           <= 1'b0;
      pll_mult         <= 2'h0;
      pll_prediv       <= 2'h0;
      fail_safe_mon_en <= 1'b0;
      slow_rc_run      <= 1'b0;
      wdt_reset        <= 1'b0;
    end else begin
      cpu_clk_en    <= (state_next == wsc_pkg::ST_RUN);
      periph_clk_en <= (state_next == wsc_pkg::ST_RUN) ||
                       (state_next == wsc_pkg::ST_IDLE);
      // Only a kept low-frequency crystal survives Sleep
      osc_run <= (state_next != wsc_pkg::ST_SLEEP) ||
                 (src_lp && lp_keep_reg);
      pll_en     <= uses_pll && (state_next != wsc_pkg::ST_SLEEP);
      pll_mult   <= uses_pll ? prim_reg[1:0] : 2'h0;
      pll_prediv <= (uses_pll && src_prim && pkind == `WSC_PK_HS) ?
                    (prim_reg[2] ? 2'h2 : 2'h1) : 2'h0;
      // Nothing to monitor while the clock is stopped
      fail_safe_mon_en <= (state_next != wsc_pkg::ST_SLEEP);
      slow_rc_run      <= wdt_on;
      // Overflow resets outside Sleep only
      wdt_reset <= wdt_ovf && !sleeping;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second oscillator pin: Fosc/4 out in RC clock-out mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg    <= 2'h0;
      osc2_wave  <= 1'b0;
      osc2_oe    <= 1'b0;
      osc2_is_io <= 1'b0;
    end else begin
      div_reg    <= div_reg + 2'h1;
      osc2_wave  <= div_reg[1];
      osc2_oe    <= src_prim && pkind == `WSC_PK_ERC && !prim_reg[2];
      osc2_is_io <= src_prim && (pkind == `WSC_PK_EXTCLK ||
                    (pkind == `WSC_PK_ERC && prim_reg[2]));
    end
  end

endmodule

// ---- verification/wsc_top_checker.sv ----
// Port-level checks for the watchdog and sleep controller.
// Sees only top ports; bound from the bench top file.
`timescale 1ns/1ns
module wsc_top_checker (
  input wire logic       aclk,               // Clock
  input wire logic       aresetn,            // Reset, low
  input wire logic       s_axi_awvalid,      // Addr valid
  input wire logic       s_axi_awready,      // Addr ready
  input wire logic       s_axi_wvalid,       // Data valid
  input wire logic       s_axi_wready,       // Data ready
  input wire logic       s_axi_bvalid,       // Resp valid
  input wire logic       cpu_clk_en,         // CPU gate
  input wire logic       periph_clk_en,      // Periph gate
  input wire logic       osc_run,            // Osc enable
  input wire logic       fail_safe_mon_en,   // Monitor on
  input wire logic [1:0] pll_prediv,         // Pre-divider
  input wire logic       wdt_reset,          // Reset pulse
  input wire logic       supply_drop_enable, // Detector on
  input wire logic [3:0] supply_drop_level,  // Threshold
  input wire logic       osc2_oe,            // Pin drive
  input wire logic       osc2_is_io          // Pin is I/O
);
  ////////////////////////////////////////
  // One clock domain, so defaults save repetition
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("Late write response");
  a_level_by_write: assert property (
    !$stable(supply_drop_level) |-> $past(s_axi_wvalid)
    || $past(s_axi_wvalid, 2)) else $error("Level moved alone");
  a_sd_en_write: assert property (
    !$stable(supply_drop_enable) |-> $past(s_axi_wvalid)
    || $past(s_axi_wvalid, 2)) else $error("Enable moved alone");
  a_wdt_one_shot: assert property (
    wdt_reset |=> !wdt_reset) else $error("Reset pulse too long");
  a_cpu_peri: assert property (
    cpu_clk_en |-> periph_clk_en) else $error("CPU on, periph off");
  a_monitor_osc: assert property (
    fail_safe_mon_en |-> osc_run) else $error("Monitor without clock");
  a_prediv_code: assert property (
    pll_prediv != 2'h3) else $error("Bad pre-divider");
  a_pin_free: assert property (
    osc2_is_io |-> !osc2_oe) else $error("I/O pin driven");
  ////////////////////////////////////////
  // Main scenarios reached
  c_wdt: cover property (wdt_reset);
  c_sleep: cover property (!periph_clk_en);
  c_resp: cover property (s_axi_bvalid);
endmodule

// ---- verification/wsc_top_bench.sv ----
// Self-checking bench for the watchdog and sleep controller.
// Drives AXI4-Lite and pins itself; short counts for speed.
`timescale 1ns/1ns
module wsc_top_bench;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, watchdog_fuse_enable = 1'h1;
  logic clk_switch_cfg = 1'h0, slow_internal_rc = 1'h0;
  logic reference_pin = 1'h0, pll_locked = 1'h0, brownout_reset = 1'h0;
  logic master_clear_pin = 1'h0, irq_wake = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF, supply_drop_level;
  logic [2:0] osc_group_cfg = 3'h0;
  logic [4:0] primary_osc_cfg = 5'h00;
  logic [2:0] cause [4] = '{3'h4, 3'h4, 3'h2, 3'h1};
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_clk_en, periph_clk_en, osc_run, pll_en;
  logic fail_safe_mon_en, slow_rc_run, wdt_reset, supply_drop_enable;
  logic osc2_wave, osc2_oe, osc2_is_io;
  logic [1:0] s_axi_bresp, s_axi_rresp, pll_mult, pll_prediv, rsp;
  int n_fail = 0, checked = 0, n_wdt = 0, k;
  wsc_top #(.POWERUP_TIMER_CYC(20), .OST_CYC(8), .WDT_W(4)) wsc_top_i (.*);
  ////////////////////////////////////////
  // Clock, and a tally of reset pulses
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (wdt_reset) n_wdt++;

  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Both channels offered together; bready held until answered
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'h1;
    s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp; s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 1'h0;
  endtask
  // Slow RC rises ten cycles apart, well above the sync delay
  task rc(input int n);
    repeat (n) begin
      repeat (5) @(posedge aclk); slow_internal_rc <= 1'h1;
      repeat (5) @(posedge aclk); slow_internal_rc <= 1'h0;
    end
    repeat (10) @(posedge aclk);
  endtask
  task wt;
    k = 0;
    while (cpu_clk_en !== 1'h1 && k < 2000) begin
      @(posedge aclk); k++;
    end
    if (k >= 2000) n_fail++;
  endtask
  // Mid-run reset; fuse levels are only taken at boot
  task rst(input logic [2:0] g, input logic [4:0] p);
    aresetn <= 1'h0; osc_group_cfg <= g; primary_osc_cfg <= p;
    repeat (12) @(posedge aclk); aresetn <= 1'h1; wt;
  endtask
  task wrap_up;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #3_000_000; n_fail++; wrap_up;
  end
  initial begin
    repeat (12) @(posedge aclk); aresetn <= 1'h1;
    wt; rd(8'h00); chk(rdat, 32'h10);
    rd(8'h0C); chk(rdat[5], 1'h1); chk(slow_rc_run, 1'h1);
    wr(8'h10, 32'h0); chk(rsp, 2'h2); rd(8'h10); chk(rsp, 2'h2);
    $display("test regs done");
    rc(15); chk(n_wdt, 0); rc(1); chk(n_wdt, 1);
    rc(12); wr(8'h04, 32'h1); rc(12); chk(n_wdt, 1);
    rc(4); chk(n_wdt, 2);
    $display("test watchdog done");
    wt; wr(8'h04, 32'h6); repeat (3) @(posedge aclk);
    chk({cpu_clk_en, periph_clk_en, osc_run}, 32'h0);
    rc(16); wt; chk(n_wdt, 2); chk(cpu_clk_en, 1'h1);
    rd(8'h00); chk(rdat[4], 1'h0);
    $display("test sleep done");
    // Idle, then Sleep left by interrupt, master clear, brown-out
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, i ? 32'h6 : 32'h2); repeat (3) @(posedge aclk);
      chk({cpu_clk_en, periph_clk_en}, i ? 32'h0 : 32'h1);
      {irq_wake, master_clear_pin, brownout_reset} <= cause[i];
      wt; {irq_wake, master_clear_pin, brownout_reset} <= 3'h0;
      chk(cpu_clk_en, 1'h1);
      if (i > 0) chk(k >= 100 && k < 140, 1'h1);
    end
    $display("test wake done");
    reference_pin <= 1'h1; s_axi_wstrb <= 4'h2; wr(8'h00, 32'h1A00);
    repeat (2) @(posedge aclk);
    chk(supply_drop_level, 4'hA); chk(supply_drop_enable, 1'h1);
    rd(8'h00); chk(rdat & 32'hFF00, 32'h3A00);
    $display("test supply done");
    // Each clock source needs its own boot, as fuses load only there
    pll_locked <= 1'h1; rst(3'h3, 5'h17);
    chk(k >= 328 && k < 340, 1'h1);
    chk({pll_en, pll_mult, pll_prediv, osc2_is_io}, 32'h3C);
    rst(3'h3, 5'h18);
    chk(k >= 100 && k < 110, 1'h1);
    chk({osc2_oe, osc2_is_io, fail_safe_mon_en, pll_en}, 32'hA);
    rdat[0] = osc2_wave; repeat (2) @(posedge aclk);
    chk(osc2_wave, !rdat[0]);
    s_axi_wstrb <= 4'hF; rst(3'h2, 5'h00);
    chk(k >= 128 && k < 140, 1'h1);
    wr(8'h08, 32'h100); wr(8'h04, 32'h6); repeat (3) @(posedge aclk);
    chk({cpu_clk_en, osc_run}, 32'h1);
    irq_wake <= 1'h1; wt; irq_wake <= 1'h0;
    chk(k >= 100 && k < 110, 1'h1);
    $display("test clocks done");
    wrap_up;
  end
endmodule
bind wsc_top wsc_top_checker wsc_top_checker_i (.*);
